// ### lsd_host_model.sv
// Purpose: host model driving the four-wire serial link of the decoder
// Assumes: strobe levels held 8 mclk, twice the 4 mclk sync need
// Notes: data line has a pull-up, so a released line reads 1

////////////////////////////////////////
module lsd_host_model
(
  input wire logic mclk,
  input wire logic dataOut,
  input wire logic dataOeN,
  output logic csN,
  output logic wrN,
  output logic rdN,
  output logic dataIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic hostOe;
  logic hostBit;

  // Wire level: host first, then device, else pull-up
  assign dataIn = hostOe ? hostBit : (!dataOeN ? dataOut : 1'b1);

  // Idle pins at time zero
  initial
  begin
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    hostOe = 1'b0;
    hostBit = 1'b0;
  end

  // Pins move 1 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Select high ends a frame; select low opens one
  task automatic select(input logic lvl);
    csN = lvl;
    tick(8);
  endtask

  // First bit at the top of the count; data set up before wr rises
  task automatic sendBits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      wrN = 1'b0;
      hostOe = 1'b1;
      hostBit = v[i];
      tick(8);
      wrN = 1'b1;
      tick(8);
    end
    hostOe = 1'b0;
  endtask

  // Nibble goes lowest bit first
  task automatic sendNib(input logic [3:0] d);
    sendBits({12'h000, d[0], d[1], d[2], d[3]}, 4);
  endtask

  // Bit sampled at the rd rise that follows each fall
  task automatic readNib(output logic [3:0] nib);
    for (int i = 0; i < 4; i++)
    begin
      rdN = 1'b0;
      tick(8);
      nib[i] = dataIn;
      rdN = 1'b1;
      tick(8);
    end
  endtask
endmodule // lsd_host_model

// ### lsd_pkg.sv
// Purpose: shared constants and types for the serial display command decoder
// Assumes: one 100 MHz clock, pins synchronised in the top module
// Notes: command words are shifted in first printed bit at the top
// Function
// RULE1: ID 110 reads display RAM nibble
// RULE2: ID 101 writes nibble into display RAM
// RULE3: ID 101 also allows read then rewrite
// RULE4: ID 100 enters command mode
// RULE5: 7-bit address MSB first, nibble LSB first
// RULE6: Further commands need no repeated ID
// RULE7: Chip select high discards current mode
// RULE8: Host sends fresh ID after select
// RULE9: Stop oscillator and bias command, default; the code leaves oscOn set while extClockSel is 1
// RULE10: Start the system oscillator command
// RULE11: Display off and on commands, off default
// RULE12: Time base output disable and enable
// RULE13: Watchdog flag output disable and enable
// RULE14: Stop the tone output pair
// RULE15: Start tone pair at high pitch
// RULE16: Start tone pair at low pitch
// RULE17: Clear time base and watchdog counts
// RULE18: Select internal or external clock source
// RULE19: Three-bit divider select, default seven
// RULE20: Test mode entry and normal mode
// RULE21: Reset defaults for every setting
// RULE22: Host rewrites configuration after power-up
// RULE23: Select high ignores strobes, resets interface
// RULE24: Sample data on write strobe rise
// RULE25: Drive read bit after read strobe fall
// RULE26: Overflow output held low until cleared
// RULE27: Overflow output disable and enable commands
// RULE28: Nine-bit commands, last bit ignored
package lsd_pkg;
  localparam int ID_W = 3;
  localparam logic [2:0] ID_READ = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD = 3'h4;
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int CMD_W = 9;
  localparam int RAM_WORDS = 96;
  localparam int FIFO_DEPTH = 32;
  localparam logic [ADDR_W-1:0] RAM_LAST = 7'h5F;
  localparam logic [3:0] ID_LAST_BIT = 4'h2;
  localparam logic [3:0] ADDR_LAST_BIT = 4'h6;
  localparam logic [3:0] NIB_LAST_BIT = 4'h3;
  localparam logic [3:0] CMD_LAST_BIT = 4'h8;
  localparam logic [2:0] DIV_RESET = 3'h7;
  localparam int DIV_LSB = 1;

  typedef enum logic [4:0] {
    ST_ID = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_CMD = 5'h08,
    ST_SKIP = 5'h10
  } lsd_state_e;

  typedef struct packed {
    logic oscOn;
    logic displayOn;
    logic timebaseOutEn;
    logic watchdogFlagEn;
    logic toneOn;
    logic toneHigh;
    logic extClockSel;
    logic flagOutEn;
    logic [2:0] divSel;
    logic testMode;
  } lsd_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] ramWordAddress;
    logic [NIB_W-1:0] ramNibble;
  } lsd_wreq_s;

  localparam lsd_cfg_s CFG_RESET = '{oscOn: 1'b0, displayOn: 1'b0, timebaseOutEn: 1'b0,
    watchdogFlagEn: 1'b0, toneOn: 1'b0, toneHigh: 1'b0, extClockSel: 1'b0,
    flagOutEn: 1'b0, divSel: DIV_RESET, testMode: 1'b0};
endpackage

// ### lsd_serial_cmd_decoder.sv
// Purpose: serial front end: mode ID, RAM access and command decode
// Assumes: pins arrive asynchronously; strobes far slower than mclk
// Notes: writes pass a FIFO to the RAM; ramHold stalls that drain

////////////////////////////////////////////////////////////////////////////////
module lsd_fifo
  import lsd_pkg::*;
#(
  parameter int W = 11,
  parameter int DEPTH = 32
)
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire logic push = inValid & inReady;
  wire logic pop = outValid & outReady;

  // Extra pointer bit tells full from empty
  assign inReady = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
  assign outValid = wp != rp;
  assign outData = mem[rp[AW-1:0]];

  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp[AW-1:0]] <= inData;
  end

  // Pointer update
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
    end
  end
endmodule // lsd_fifo

////////////////////////////////////////////////////////////////////////////////
module lsd_serial_cmd_decoder
  import lsd_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOeN,
  input wire logic ramHold,
  input wire logic watchdogTimeout,
  output logic irqOut,
  output logic irqOeN,
  output lsd_cfg_s cfg,
  output logic biasOn,
  output logic timebaseClear,
  output logic watchdogClear,
  output logic writeDropped
);
  logic rstMeta;
  logic rstSync;
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic wrPrev;
  logic rdPrev;
  lsd_state_e state;
  lsd_state_e next_state;
  logic [3:0] bitCnt;
  logic [1:0] rdCnt;
  logic [2:0] idSh;
  logic modeRead;
  logic [ADDR_W-1:0] addr;
  logic [NIB_W-1:0] nib;
  logic [CMD_W-1:0] cmdSh;
  logic [NIB_W-1:0] ram [RAM_WORDS];
  logic flagLatch;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Pin synchronisers; idle pins read high like the pull-ups
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      pinMeta <= 4'hF;
      pinSync <= 4'hF;
      wrPrev <= 1'b1;
      rdPrev <= 1'b1;
    end
    else
    begin
      pinMeta <= {csN, wrN, rdN, dataIn};
      pinSync <= pinMeta;
      wrPrev <= pinSync[2];
      rdPrev <= pinSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe edges, gated by chip select
  wire logic csHigh = pinSync[3]; // [RULE23]
  wire logic dBit = pinSync[0];
  wire logic wrRise = ~csHigh & pinSync[2] & ~wrPrev; // [RULE24]
  wire logic rdFall = ~csHigh & ~pinSync[1] & rdPrev; // [RULE25]
  wire logic [2:0] idNext = {idSh[1:0], dBit};
  wire logic [CMD_W-1:0] cmdWord = {cmdSh[CMD_W-2:0], dBit};
  wire logic idDone = (state == ST_ID) & wrRise & (bitCnt == ID_LAST_BIT);
  wire logic addrDone = (state == ST_ADDR) & wrRise & (bitCnt == ADDR_LAST_BIT);
  wire logic wrInData = (state == ST_DATA) & wrRise & ~modeRead;
  wire logic nibDone = wrInData & (bitCnt == NIB_LAST_BIT);
  wire logic cmdDone = (state == ST_CMD) & wrRise & (bitCnt == CMD_LAST_BIT); // [RULE28]
  wire logic rdInData = (state == ST_DATA) & rdFall;
  wire logic readStep = rdInData & modeRead & (rdCnt == 2'h3);
  wire logic addrStep = nibDone | readStep;
  wire logic [NIB_W-1:0] ramQ = (addr <= RAM_LAST) ? ram[addr] : '0;
  wire logic [NIB_W-1:0] nibFull = {dBit, nib[2:0]};

  // Next state of the frame parser
  always_comb
  begin
    next_state = state;
    case (state)
      ST_ID:
        if (idDone)
        begin
          if (idNext == ID_READ || idNext == ID_WRITE)
            next_state = ST_ADDR; // [RULE1] [RULE2]
          else if (idNext == ID_CMD)
            next_state = ST_CMD; // [RULE4]
          else
            next_state = ST_SKIP;
        end
      ST_ADDR:
        if (addrDone)
          next_state = ST_DATA; // [RULE5]
      ST_DATA, ST_CMD, ST_SKIP:
        next_state = state; // [RULE6]
      default:
        next_state = ST_ID;
    endcase
    if (csHigh)
      next_state = ST_ID; // [RULE7] [RULE23]
  end

  // Frame parser registers
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      state <= ST_ID;
    else
      state <= next_state;
  end

  // Bit counter and shift registers; chip select high clears only bitCnt and rdCnt
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      bitCnt <= '0;
      rdCnt <= '0;
      idSh <= '0;
      modeRead <= 1'b0;
      addr <= '0;
      nib <= '0;
      cmdSh <= '0;
    end
    else if (csHigh)
    begin
      bitCnt <= '0;
      rdCnt <= '0;
    end
    else if (wrRise && (idDone || addrDone || nibDone || cmdDone))
    begin
      bitCnt <= '0;
      if (idDone)
        modeRead <= (idNext == ID_READ); // [RULE1]
      // Last address bit lands with the phase change, not a bit later
      if (addrDone)
        addr <= {addr[ADDR_W-2:0], dBit}; // [RULE5]
      if (nibDone)
      begin
        addr <= addr + 1'b1;
        rdCnt <= '0;
      end
    end
    else if (wrRise)
    begin
      bitCnt <= bitCnt + 1'b1;
      idSh <= idNext;
      if (state == ST_ADDR)
        addr <= {addr[ADDR_W-2:0], dBit}; // [RULE5]
      if (wrInData)
        nib[bitCnt[1:0]] <= dBit; // [RULE5] [RULE3]
      cmdSh <= cmdWord;
    end
    else if (rdInData)
    begin
      rdCnt <= rdCnt + 1'b1; // [RULE3]
      if (readStep)
        addr <= addr + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data pin; released as soon as chip select rises
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      dataOut <= 1'b1;
      dataOeN <= 1'b1;
    end
    else if (csHigh)
      dataOeN <= 1'b1;
    else if (rdInData)
    begin
      dataOut <= ramQ[rdCnt]; // [RULE1] [RULE3] [RULE25]
      dataOeN <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path through the FIFO; a full FIFO drops the nibble
  lsd_wreq_s fifoIn;
  lsd_wreq_s fifoOut;
  logic fifoInReady;
  logic fifoOutValid;
  wire logic drainReady = ~ramHold;
  assign fifoIn = '{ramWordAddress: addr, ramNibble: nibFull};

  lsd_fifo #(.W($bits(lsd_wreq_s)), .DEPTH(FIFO_DEPTH)) wrFifo (
    .clk(mclk),
    .rstN(rstSync),
    .inValid(nibDone),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .outData(fifoOut)
  );

  // Reads see the RAM only; pending FIFO words are not forwarded
  always_ff @(posedge mclk)
  begin
    if (fifoOutValid && drainReady && fifoOut.ramWordAddress <= RAM_LAST)
      ram[fifoOut.ramWordAddress] <= fifoOut.ramNibble; // [RULE2]
  end

  // Lost write indicator, sticky until reset
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      writeDropped <= 1'b0;
    else if (nibDone && !fifoInReady)
      writeDropped <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; unlisted codes change nothing
  wire logic [7:0] op = cmdWord[8:1]; // [RULE28]
  wire logic isSysDis = op == 8'h00;
  wire logic isFlagDis = op[7:5] == 3'h4 && !op[3];
  wire logic isWdClr = op == 8'h0F;

  // Configuration registers
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      cfg <= CFG_RESET; // [RULE21] [RULE9] [RULE11] [RULE12] [RULE13]
    else if (cmdDone)
    begin
      casez (op)
        8'h00: if (!cfg.extClockSel) cfg.oscOn <= 1'b0; // [RULE9]
        8'h01: cfg.oscOn <= 1'b1; // [RULE10]
        8'h02: cfg.displayOn <= 1'b0; // [RULE11]
        8'h03: cfg.displayOn <= 1'b1; // [RULE11]
        8'h04: cfg.timebaseOutEn <= 1'b0; // [RULE12]
        8'h06: cfg.timebaseOutEn <= 1'b1; // [RULE12]
        8'h05: cfg.watchdogFlagEn <= 1'b0; // [RULE13]
        8'h07: cfg.watchdogFlagEn <= 1'b1; // [RULE13]
        8'h08: cfg.toneOn <= 1'b0; // [RULE14]
        8'b0001_10??: cfg.extClockSel <= 1'b0; // [RULE18]
        8'b0001_11??: cfg.extClockSel <= 1'b1; // [RULE18]
        8'b010?_????:
        begin
          cfg.toneOn <= 1'b1; // [RULE15]
          cfg.toneHigh <= 1'b1;
        end
        8'b0110_????:
        begin
          cfg.toneOn <= 1'b1; // [RULE16]
          cfg.toneHigh <= 1'b0;
        end
        8'b100?_0???: cfg.flagOutEn <= 1'b0; // [RULE27]
        8'b100?_1???: cfg.flagOutEn <= 1'b1; // [RULE27]
        8'b101?_0???: cfg.divSel <= op[2:0]; // [RULE19]
        8'hE0: cfg.testMode <= 1'b1; // [RULE20]
        8'hE3: cfg.testMode <= 1'b0; // [RULE20]
        default: cfg <= cfg;
      endcase
    end
  end

  // Bias follows oscillator and display together
  assign biasOn = cfg.oscOn & cfg.displayOn; // [RULE9]

  // Clear pulses, one cycle each
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      timebaseClear <= 1'b0;
      watchdogClear <= 1'b0;
    end
    else
    begin
      timebaseClear <= cmdDone && op == 8'h0D; // [RULE17]
      watchdogClear <= cmdDone && isWdClr; // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out latch; a new time-out wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      flagLatch <= 1'b0;
    else if (watchdogTimeout && cfg.watchdogFlagEn)
      flagLatch <= 1'b1;
    else if (cmdDone && (isWdClr || isFlagDis))
      flagLatch <= 1'b0; // [RULE26]
  end

  // Open-drain overflow pin: enable low pulls the wire low
  assign irqOut = 1'b0;
  assign irqOeN = ~(flagLatch & cfg.flagOutEn); // [RULE26] [RULE27]

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync);

  a_cs_mode_reset: assert property (csHigh |=> state == ST_ID) // [RULE7]
    else $error("chip select high did not reset mode");
  a_cs_pin_release: assert property (csHigh |=> dataOeN) // [RULE23]
    else $error("data pin driven while deselected");
  a_read_id: assert property (idDone && idNext == ID_READ && !csHigh
    |=> state == ST_ADDR && modeRead) // [RULE1]
    else $error("read ID not taken");
  a_write_id: assert property (idDone && idNext == ID_WRITE && !csHigh
    |=> state == ST_ADDR && !modeRead) // [RULE2]
    else $error("write ID not taken");
  a_cmd_id: assert property (idDone && idNext == ID_CMD && !csHigh |=> state == ST_CMD) // [RULE4]
    else $error("command ID not taken");
  a_addr_len: assert property (state == ST_ADDR && !csHigh && !addrDone ##1 addrDone
    |=> state == ST_DATA && bitCnt == 4'h0) // [RULE5]
    else $error("address phase length wrong");
  a_cmd_repeat: assert property (cmdDone && !csHigh |=> state == ST_CMD && bitCnt == 4'h0) // [RULE6]
    else $error("command mode left after a word");
  a_nib_push: assert property (nibDone && fifoInReady |=> fifoOutValid) // [RULE2]
    else $error("written nibble not queued");
  a_sysdis_off: assert property (cmdDone && isSysDis && !cfg.extClockSel |=> !cfg.oscOn) // [RULE9]
    else $error("oscillator still on");
  a_tone_high: assert property (cmdDone && op[7:5] == 3'h2 |=> cfg.toneOn && cfg.toneHigh) // [RULE15]
    else $error("high tone not started");
  a_div_sel: assert property (cmdDone && op[7:5] == 3'h5 && !op[3]
    |=> cfg.divSel == $past(op[2:0])) // [RULE19]
    else $error("divider select wrong");
  a_rd_drive: assert property (rdInData && !csHigh |=> !dataOeN ##0 dataOut == $past(ramQ[rdCnt])) // [RULE25]
    else $error("read bit not driven");
  a_flag_hold: assert property (flagLatch && cfg.flagOutEn && !(cmdDone && (isWdClr || isFlagDis))
    |=> !irqOeN) // [RULE26]
    else $error("overflow output released early");

  c_read_nibble: cover property (readStep);
  c_write_nibble: cover property (nibDone);
  c_cmd_twice: cover property (cmdDone ##[1:1000] cmdDone);
  c_flag_out: cover property (!irqOeN);
endmodule // lsd_serial_cmd_decoder

// ### lsd_serial_cmd_decoder_bench.sv
// Purpose: self-checking bench for the serial command decoder
// Assumes: host model paces all strobes; no random stimulus
// Notes: expected config comes from a bench-side command decode

////////////////////////////////////////
module lsd_serial_cmd_decoder_bench
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rstn, csN, wrN, rdN, dataIn, dataOut, dataOeN, ramHold, watchdogTimeout;
  logic irqOut, irqOeN, biasOn, timebaseClear, watchdogClear, writeDropped;
  lsd_cfg_s cfg, exp;
  int miscompares = 0;
  int nCompared = 0;
  int tbPulses = 0;
  int wdPulses = 0;
  // Command list; the test mode entry code is never sent by a host
  logic [8:0] cmds [23] = '{9'h003, 9'h006, 9'h00C, 9'h00F, 9'h0BF, 9'h0D5, 9'h010,
    9'h130, 9'h166, 9'h038, 9'h001, 9'h037, 9'h1C2, 9'h1C6, 9'h1FF, 9'h004, 9'h008,
    9'h00A, 9'h10F, 9'h141, 9'h000, 9'h01A, 9'h01E};

  always #5 mclk = ~mclk;

  lsd_serial_cmd_decoder u_lsd_serial_cmd_decoder (
    .mclk(mclk),
    .rstn(rstn),
    .csN(csN),
    .wrN(wrN),
    .rdN(rdN),
    .dataIn(dataIn),
    .dataOut(dataOut),
    .dataOeN(dataOeN),
    .ramHold(ramHold),
    .watchdogTimeout(watchdogTimeout),
    .irqOut(irqOut),
    .irqOeN(irqOeN),
    .cfg(cfg),
    .biasOn(biasOn),
    .timebaseClear(timebaseClear),
    .watchdogClear(watchdogClear),
    .writeDropped(writeDropped)
  );
  lsd_host_model u_lsd_host_model (
    .mclk(mclk),
    .dataOut(dataOut),
    .dataOeN(dataOeN),
    .csN(csN),
    .wrN(wrN),
    .rdN(rdN),
    .dataIn(dataIn)
  );

  // Count clear pulses; a stuck level would count many
  always @(posedge mclk)
  begin
    tbPulses <= tbPulses + int'(timebaseClear === 1'b1);
    wdPulses <= wdPulses + int'(watchdogClear === 1'b1);
  end

  // Bench-side decode; unlisted codes leave everything alone
  function automatic lsd_cfg_s nextCfg(input lsd_cfg_s c, input logic [8:0] w);
    lsd_cfg_s n;
    n = c;
    casez (w[8:1])
      8'b0000_0000: if (!c.extClockSel) n.oscOn = 1'b0;
      8'b0000_0001: n.oscOn = 1'b1;
      8'b0000_0010: n.displayOn = 1'b0;
      8'b0000_0011: n.displayOn = 1'b1;
      8'b0000_0100: n.timebaseOutEn = 1'b0;
      8'b0000_0110: n.timebaseOutEn = 1'b1;
      8'b0000_0101: n.watchdogFlagEn = 1'b0;
      8'b0000_0111: n.watchdogFlagEn = 1'b1;
      8'b0000_1000: n.toneOn = 1'b0;
      8'b010?_????: {n.toneOn, n.toneHigh} = 2'b11;
      8'b0110_????: {n.toneOn, n.toneHigh} = 2'b10;
      8'b0001_10??: n.extClockSel = 1'b0;
      8'b0001_11??: n.extClockSel = 1'b1;
      8'b100?_0???: n.flagOutEn = 1'b0;
      8'b100?_1???: n.flagOutEn = 1'b1;
      8'b101?_0???: n.divSel = w[3:1];
      8'b1110_0000: n.testMode = 1'b1;
      8'b1110_0011: n.testMode = 1'b0;
      default: n = c;
    endcase
    return n;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    nCompared++;
    if (got !== want)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, want);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Fresh select, mode ID, then start address; select high drops the old mode
  task automatic openData(input logic [2:0] id, input logic [6:0] a);
    u_lsd_host_model.select(1'b1);
    u_lsd_host_model.select(1'b0);
    u_lsd_host_model.sendBits({13'h0000, id}, 3);
    u_lsd_host_model.sendBits({9'h000, a}, 7);
  endtask

  task automatic readCheck(input logic [3:0] want);
    logic [3:0] n;
    u_lsd_host_model.readNib(n);
    check(16'(n), 16'(want), "nibble");
  endtask

  task automatic sendCmd(input logic [8:0] w);
    u_lsd_host_model.sendBits(16'(w), 9);
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    ramHold = 1'b0;
    watchdogTimeout = 1'b0;
    repeat (20) @(posedge mclk);
    #1 rstn = 1'b1;
    u_lsd_host_model.tick(6);
    check(16'(cfg), 16'(CFG_RESET), "reset cfg");
    check(16'({irqOeN, dataOeN, biasOn, writeDropped}), 16'h000C, "reset pins");
    // Successive write, then successive read of the same words
    openData(ID_WRITE, 7'h10);
    u_lsd_host_model.sendNib(4'hA);
    u_lsd_host_model.sendNib(4'h5);
    u_lsd_host_model.sendNib(4'h3);
    openData(ID_READ, 7'h10);
    readCheck(4'hA);
    readCheck(4'h5);
    readCheck(4'h3);
    // Update in place: read old, write new, address then moves on
    openData(ID_WRITE, 7'h11);
    readCheck(4'h5);
    u_lsd_host_model.sendNib(4'hC);
    readCheck(4'h3);
    openData(ID_WRITE, 7'h60);
    u_lsd_host_model.sendNib(4'hF);
    openData(ID_READ, 7'h11);
    readCheck(4'hC);
    openData(ID_READ, 7'h60);
    readCheck(4'h0);
    u_lsd_host_model.select(1'b1);
    // Strobes while deselected must do nothing
    exp = CFG_RESET;
    u_lsd_host_model.sendBits({4'h0, ID_CMD, 9'h006}, 12);
    check(16'(cfg), 16'(exp), "deselected");
    // Unknown mode ID: the rest of the frame is skipped
    u_lsd_host_model.select(1'b0);
    u_lsd_host_model.sendBits({4'h0, 3'h3, 9'h006}, 12);
    check(16'(cfg), 16'(exp), "unknown ID");
    u_lsd_host_model.select(1'b1);
    // Partial word then select high; the next frame must realign
    u_lsd_host_model.select(1'b0);
    u_lsd_host_model.sendBits({13'h0000, ID_CMD}, 3);
    u_lsd_host_model.sendBits(16'h0000, 5);
    u_lsd_host_model.select(1'b1);
    u_lsd_host_model.select(1'b0);
    u_lsd_host_model.sendBits({13'h0000, ID_CMD}, 3);
    foreach (cmds[i])
    begin
      sendCmd(cmds[i]);
      exp = nextCfg(exp, cmds[i]);
      check(16'(cfg), 16'(exp), "cfg");
      check(16'(biasOn), 16'(exp.oscOn & exp.displayOn), "bias");
    end
    check(16'(tbPulses), 16'h0001, "timebase clear");
    check(16'(wdPulses), 16'h0001, "watchdog clear");
    // Overflow flag holds until cleared by command
    sendCmd(9'h00E);
    sendCmd(9'h130);
    watchdogTimeout = 1'b1;
    u_lsd_host_model.tick(1);
    watchdogTimeout = 1'b0;
    u_lsd_host_model.tick(20);
    check(16'({irqOeN, irqOut}), 16'h0000, "flag set");
    sendCmd(9'h01E);
    check(16'(irqOeN), 16'h0001, "flag cleared");
    watchdogTimeout = 1'b1;
    u_lsd_host_model.tick(1);
    watchdogTimeout = 1'b0;
    u_lsd_host_model.tick(4);
    check(16'(irqOeN), 16'h0000, "flag again");
    sendCmd(9'h100);
    check(16'(irqOeN), 16'h0001, "flag off");
    // Fill the write queue with the RAM stalled, then drain it
    ramHold = 1'b1;
    openData(ID_WRITE, 7'h20);
    for (int i = 0; i < 32; i++)
      u_lsd_host_model.sendNib(i[3:0]);
    check(16'(writeDropped), 16'h0000, "queue full");
    u_lsd_host_model.sendNib(4'h9);
    check(16'(writeDropped), 16'h0001, "queue refused");
    ramHold = 1'b0;
    u_lsd_host_model.tick(60);
    openData(ID_READ, 7'h20);
    readCheck(4'h0);
    readCheck(4'h1);
    openData(ID_READ, 7'h3F);
    readCheck(4'hF);
    u_lsd_host_model.select(1'b1);
    results();
  end

  // Hang guard: whole run needs about 9300 cycles
  initial
  begin
    #400us;
    miscompares++;
    results();
  end
endmodule // lsd_serial_cmd_decoder_bench
